/* pep_host_model.sv */
// host processor model on the parallel slave port pins
`timescale 1ns/1ns
module pep_host_model (
	// clock
	input wire logic core_clk,
	// strobes and data driven toward the block
	output logic [2:0] pins,
	output logic [7:0] data,
	// data pins as seen on the wire
	input wire logic [7:0] data_level
);
	// ------------------------------------------------------------
	// strobes idle high, bit 0 read, bit 1 write, bit 2 select
	// ------------------------------------------------------------
	initial begin
		pins = 3'h7;
		data = 8'h00;
	end

	// plain levels for general purpose inputs
	task automatic set_pins(input logic [2:0] v);
		@(posedge core_clk);
		pins <= v;
	endtask : set_pins

	// write: strobe held low 4 cycles, data held 3 cycles past the end
	task automatic host_write(input logic [7:0] w);
		@(posedge core_clk);
		data <= w;
		pins <= 3'h1;
		repeat (4) @(posedge core_clk);
		pins <= 3'h7;
		repeat (3) @(posedge core_clk);
		data <= ~w; // released bus shows the inverse, never the old word
	endtask : host_write

	// read: word taken late in the strobe, after the synchronisers
	task automatic host_read(output logic [7:0] r);
		@(posedge core_clk);
		pins <= 3'h2;
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		r = data_level;
		@(posedge core_clk);
		pins <= 3'h7;
		repeat (3) @(posedge core_clk);
	endtask : host_read
endmodule : pep_host_model

/* pep_pkg.sv */
// package for the port e pin block and its slave port status bits
package pep_pkg;

	// ------------------------------------------------------------
	// register byte addresses on the register bus
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_PIN_LEVELS = 8'h00;
	localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h04;
	localparam logic [7:0] OFF_DIR_CTRL = 8'h08;
	localparam logic [7:0] OFF_ANALOG_SEL = 8'h0C;
	localparam logic [7:0] OFF_SLAVE_DATA = 8'h10;

	// ------------------------------------------------------------
	// field positions of the direction and slave control register
	// ------------------------------------------------------------
	localparam int BIT_INPUT_FULL = 7;
	localparam int BIT_OUTPUT_FULL = 6;
	localparam int BIT_OVERRUN = 5;
	localparam int BIT_SLAVE_SEL = 4;
	localparam int BIT_PIN3 = 3;
	// analog select bits of the three low pins sit at 7:5
	localparam int BIT_ANALOG_LO = 5;
	// pin roles while the slave port is on
	localparam int PIN_READ_STROBE = 0;
	localparam int PIN_WRITE_STROBE = 1;
	localparam int PIN_CHIP_SELECT = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0] LATCH_RST = 3'h0;
	localparam logic [2:0] DIR_RST = 3'h7;
	localparam logic [7:0] ANALOG_RST = 8'hFF;
	localparam logic [7:0] WORD_RST = 8'h00;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// drive of the three configurable pins
	typedef struct packed {
		logic [2:0] drive;
		logic [2:0] enable;
	} pep_pin_drive_t;

	// drive of the eight companion data pins
	typedef struct packed {
		logic [7:0] drive;
		logic enable;
	} pep_data_drive_t;

	// whole state of the block
	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [2:0] latch;
		logic [2:0] dir;
		logic slave_sel;
		logic input_full;
		logic output_full;
		logic overrun;
		logic [7:0] analog_sel;
		logic [7:0] in_word;
		logic [7:0] out_word;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic [2:0] pin_s3;
		logic [7:0] dat_s1;
		logic [7:0] dat_s2;
		logic fuse_s1;
		logic fuse_s2;
		logic vpp_s1;
		logic vpp_s2;
	} pep_state_t;

endpackage : pep_pkg

/* pep_port_e.sv */
// port e pins, direction and analog masking, and parallel slave port status
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns

// What this block does
// [R1] large package: four bits, three bidirectional
// [R2] analog-selected pin reads zero
// [R3] direction one is input, zero drives latch
// [R4] direction governs drivers even when analog
// [R5] reset makes three low pins analog
// [R6] latch register reads back latched value
// [R7] fuse clear: fourth pin is plain input
// [R8] fuse set: fourth pin is master clear
// [R9] high voltage detect always active
// [R10] small package: only fourth pin input
// [R11] input full flag bit 7
// [R12] output full flag bit 6
// [R13] overrun bit 5, sticky until software
// [R14] bit 4 selects slave port mode
// [R15] control bit 3 reads zero
// [R16] slave mode pins become host strobes
// [R17] digital output ignores analog select
// [R18] unimplemented upper bits read zero
// [R19] slave mode data pins carry port words
// [R20] data address writes latch, reads pins
module pep_port_e #(
	parameter bit LARGE_PKG = 1'b1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register bus write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// register bus write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// register bus write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// register bus read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// port pins, bit 3 is the input-only pin (low means reset request while the fuse is set)
	input wire logic [3:0] port_e_pin_level,
	output pep_pkg::pep_pin_drive_t port_e_pin_drive,
	// companion data pins used by the slave port
	input wire logic [7:0] slave_data_level,
	output pep_pkg::pep_data_drive_t slave_data_drive,
	// configuration fuse and programming voltage detector
	input wire logic master_clear_enable_fuse,
	input wire logic vpp_high_seen,
	// outputs to the reset and programming logic
	output logic master_clear_request,
	output logic programming_entry
);

	pep_pkg::pep_state_t st_reg;
	pep_pkg::pep_state_t st_next;

	logic slave_on;
	logic host_rd_now;
	logic host_rd_was;
	logic host_wr_now;
	logic host_wr_was;
	logic host_wr_end;
	logic host_rd_end;
	logic wr_fire;
	logic ar_fire;
	logic [7:0] rd_value;
	logic rd_mapped;
	logic wr_mapped;
	logic ctrl_wr;

	// ------------------------------------------------------------
	// slave port strobes, active low, read from the second stage on
	// ------------------------------------------------------------
	assign slave_on = LARGE_PKG && st_reg.slave_sel && (&st_reg.dir); // see [R14] see [R16]
	assign host_rd_now = ~st_reg.pin_s2[pep_pkg::PIN_READ_STROBE]
		& ~st_reg.pin_s2[pep_pkg::PIN_CHIP_SELECT];
	assign host_wr_now = ~st_reg.pin_s2[pep_pkg::PIN_WRITE_STROBE]
		& ~st_reg.pin_s2[pep_pkg::PIN_CHIP_SELECT];
	assign host_rd_was = ~st_reg.pin_s3[pep_pkg::PIN_READ_STROBE]
		& ~st_reg.pin_s3[pep_pkg::PIN_CHIP_SELECT];
	assign host_wr_was = ~st_reg.pin_s3[pep_pkg::PIN_WRITE_STROBE]
		& ~st_reg.pin_s3[pep_pkg::PIN_CHIP_SELECT];
	// a transfer counts when its strobe ends, so data has settled
	assign host_wr_end = slave_on & host_wr_was & ~host_wr_now; // see [R16]
	assign host_rd_end = slave_on & host_rd_was & ~host_rd_now; // see [R16]

	// ------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------
	assign s_axi_awready = ~st_reg.aw_have & ~st_reg.bvalid;
	assign s_axi_wready = ~st_reg.w_have & ~st_reg.bvalid;
	assign s_axi_arready = ~st_reg.rvalid;
	assign wr_fire = st_reg.aw_have & st_reg.w_have & ~st_reg.bvalid;
	assign ar_fire = s_axi_arvalid & s_axi_arready;
	assign ctrl_wr = wr_fire && st_reg.w_strb0 && st_reg.aw_addr == pep_pkg::OFF_DIR_CTRL;

	// address decode shared by both directions
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = a == pep_pkg::OFF_PIN_LEVELS || a == pep_pkg::OFF_OUTPUT_LATCH
			|| a == pep_pkg::OFF_DIR_CTRL || a == pep_pkg::OFF_ANALOG_SEL
			|| a == pep_pkg::OFF_SLAVE_DATA;
	endfunction : addr_known

	assign rd_mapped = addr_known(s_axi_araddr);
	assign wr_mapped = addr_known(st_reg.aw_addr);

	// ------------------------------------------------------------
	// read value mux
	// ------------------------------------------------------------
	always_comb begin
		rd_value = 8'h00;
		if (s_axi_araddr == pep_pkg::OFF_PIN_LEVELS) begin
			// pins read their level; analog ones read zero
			if (LARGE_PKG) begin
				rd_value[2:0] = st_reg.pin_s2[2:0]
					& ~st_reg.analog_sel[pep_pkg::BIT_ANALOG_LO +: 3]; // see [R2] see [R20]
			end
			// fourth pin only as a port bit while the fuse is clear
			rd_value[pep_pkg::BIT_PIN3] = ~st_reg.fuse_s2
				& st_reg.pin_s2[pep_pkg::BIT_PIN3]; // see [R7] see [R10]
		end else if (s_axi_araddr == pep_pkg::OFF_OUTPUT_LATCH) begin
			rd_value[2:0] = LARGE_PKG ? st_reg.latch : 3'h0; // see [R6] see [R18]
		end else if (s_axi_araddr == pep_pkg::OFF_DIR_CTRL && LARGE_PKG) begin
			rd_value[pep_pkg::BIT_INPUT_FULL] = st_reg.input_full; // see [R11]
			rd_value[pep_pkg::BIT_OUTPUT_FULL] = st_reg.output_full; // see [R12]
			rd_value[pep_pkg::BIT_OVERRUN] = st_reg.overrun; // see [R13]
			rd_value[pep_pkg::BIT_SLAVE_SEL] = st_reg.slave_sel; // see [R14]
			rd_value[2:0] = st_reg.dir; // bit 3 stays zero, see [R15]
		end else if (s_axi_araddr == pep_pkg::OFF_ANALOG_SEL) begin
			// the three port e select bits do not exist on the small package
			rd_value = LARGE_PKG ? st_reg.analog_sel : {3'h0, st_reg.analog_sel[4:0]};
		end else if (s_axi_araddr == pep_pkg::OFF_SLAVE_DATA && LARGE_PKG) begin
			rd_value = st_reg.in_word;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		// two-stage synchronisers for pins, data bus, fuse and detector
		st_next.pin_s1 = port_e_pin_level;
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.pin_s3 = st_reg.pin_s2[2:0];
		st_next.dat_s1 = slave_data_level;
		st_next.dat_s2 = st_reg.dat_s1;
		st_next.fuse_s1 = master_clear_enable_fuse;
		st_next.fuse_s2 = st_reg.fuse_s1;
		st_next.vpp_s1 = vpp_high_seen;
		st_next.vpp_s2 = st_reg.vpp_s1;

		// address and data channels are caught in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_have = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_have = 1'b1;
			st_next.w_data = s_axi_wdata[7:0];
			st_next.w_strb0 = s_axi_wstrb[0];
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// register write once both halves are held
		if (wr_fire) begin
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = wr_mapped ? pep_pkg::RESP_OKAY : pep_pkg::RESP_SLVERR;
			if (st_reg.w_strb0) begin
				if (st_reg.aw_addr == pep_pkg::OFF_PIN_LEVELS
					|| st_reg.aw_addr == pep_pkg::OFF_OUTPUT_LATCH) begin
					st_next.latch = st_reg.w_data[2:0]; // see [R6] see [R20]
				end else if (st_reg.aw_addr == pep_pkg::OFF_DIR_CTRL) begin
					st_next.dir = st_reg.w_data[2:0]; // see [R3]
					st_next.slave_sel = st_reg.w_data[pep_pkg::BIT_SLAVE_SEL]; // see [R14]
					st_next.overrun = st_reg.w_data[pep_pkg::BIT_OVERRUN]; // see [R13]
				end else if (st_reg.aw_addr == pep_pkg::OFF_ANALOG_SEL) begin
					st_next.analog_sel = st_reg.w_data;
				end else if (st_reg.aw_addr == pep_pkg::OFF_SLAVE_DATA) begin
					// word for the host to read
					st_next.out_word = st_reg.w_data; // see [R19]
				end
			end
		end

		// read answer, one cycle after the address is taken
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (ar_fire) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_value;
			st_next.rresp = rd_mapped ? pep_pkg::RESP_OKAY : pep_pkg::RESP_SLVERR;
			// consuming the host word empties the input buffer
			if (s_axi_araddr == pep_pkg::OFF_SLAVE_DATA) begin
				st_next.input_full = 1'b0; // see [R11]
			end
		end

		// flag sets come last so they win over same-cycle clears
		if (host_rd_end) begin
			st_next.output_full = 1'b0; // see [R12]
		end
		if (wr_fire && st_reg.w_strb0 && st_reg.aw_addr == pep_pkg::OFF_SLAVE_DATA) begin
			st_next.output_full = 1'b1; // see [R12]
		end
		if (host_wr_end) begin
			if (st_reg.input_full) begin
				// unread word kept; the new one is dropped
				st_next.overrun = 1'b1; // see [R13]
			end else begin
				st_next.in_word = st_reg.dat_s2; // see [R19]
			end
			st_next.input_full = 1'b1; // see [R11]
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.latch <= pep_pkg::LATCH_RST;
			st_reg.dir <= pep_pkg::DIR_RST;
			st_reg.analog_sel <= pep_pkg::ANALOG_RST; // see [R5]
			st_reg.in_word <= pep_pkg::WORD_RST;
			st_reg.out_word <= pep_pkg::WORD_RST;
			// strobes idle high so no false edge after reset
			st_reg.pin_s1 <= 4'hF;
			st_reg.pin_s2 <= 4'hF;
			st_reg.pin_s3 <= 3'h7;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = {24'h000000, st_reg.rdata}; // see [R18]
	assign s_axi_rresp = st_reg.rresp;

	// drivers follow direction alone; analog select never gates them
	assign port_e_pin_drive.drive = st_reg.latch; // see [R17]
	assign port_e_pin_drive.enable = LARGE_PKG ? ~st_reg.dir : 3'h0; // see [R1] see [R3] see [R4]

	// slave port read data takes priority while the host reads
	assign slave_data_drive.drive = st_reg.out_word; // see [R19]
	assign slave_data_drive.enable = slave_on & host_rd_now; // see [R19]

	// fourth pin: low level with the fuse set asks for reset
	assign master_clear_request = st_reg.fuse_s2
		& ~st_reg.pin_s2[pep_pkg::BIT_PIN3]; // see [R8]
	assign programming_entry = st_reg.vpp_s2; // see [R9]

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence host_write_ends;
		slave_on && host_wr_was && !host_wr_now;
	endsequence

	sequence host_read_ends;
		slave_on && host_rd_was && !host_rd_now;
	endsequence

	sequence read_of(logic [7:0] a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
	endsequence

	drive_follows_dir_a: assert property ( // see [R3]
		LARGE_PKG |-> port_e_pin_drive.enable == ~st_reg.dir
			&& port_e_pin_drive.drive == st_reg.latch)
		else $error("pin enable does not follow direction");

	analog_reads_zero_a: assert property ( // see [R2]
		read_of(pep_pkg::OFF_PIN_LEVELS) ##0 st_reg.analog_sel[pep_pkg::BIT_ANALOG_LO]
			|=> s_axi_rvalid && s_axi_rdata[0] == 1'b0)
		else $error("analog pin read not zero");

	ctrl_spare_zero_a: assert property ( // see [R15]
		read_of(pep_pkg::OFF_DIR_CTRL) |=> s_axi_rvalid
			&& s_axi_rdata[pep_pkg::BIT_PIN3] == 1'b0 && s_axi_rdata[31:8] == 24'h000000)
		else $error("control spare bits not zero");

	latch_readback_a: assert property ( // see [R6]
		read_of(pep_pkg::OFF_OUTPUT_LATCH) |=> s_axi_rdata[2:0] == $past(st_reg.latch)
			&& s_axi_rdata[7:3] == 5'h00)
		else $error("latch read differs from latch");

	host_write_fills_a: assert property ( // see [R11]
		host_write_ends |=> st_reg.input_full)
		else $error("input full not set after host write");

	overrun_sets_a: assert property ( // see [R13]
		host_write_ends ##0 st_reg.input_full |=> st_reg.overrun
			&& st_reg.in_word == $past(st_reg.in_word))
		else $error("overrun not flagged");

	overrun_sticky_a: assert property ( // see [R13]
		st_reg.overrun && !ctrl_wr |=> st_reg.overrun)
		else $error("overrun cleared without software");

	host_read_empties_a: assert property ( // see [R12]
		host_read_ends ##0 !(wr_fire && st_reg.aw_addr == pep_pkg::OFF_SLAVE_DATA)
			|=> !st_reg.output_full)
		else $error("output full not cleared by host read");

	master_clear_path_a: assert property ( // see [R8]
		$fell(port_e_pin_level[pep_pkg::BIT_PIN3]) && st_reg.fuse_s2
			##1 st_reg.fuse_s2 && !port_e_pin_level[pep_pkg::BIT_PIN3]
			|=> master_clear_request)
		else $error("master clear not raised two cycles after pin low");

	write_answers_a: assert property ( // see [R20]
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> ##[0:1] s_axi_bvalid)
		else $error("write response late");

endmodule : pep_port_e

/* tb_top.sv */
// self-checking bench for the port e block
`timescale 1ns/1ns
module tb_top;
	// ------------------------------------------------------------
	// clock, reset and design signals
	// ------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF; // byte lane gating left untested
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, mcr, pent;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic pin3 = 1'b1;
	logic fuse = 1'b0;
	logic vpp = 1'b0;
	logic [2:0] hpins;
	logic [7:0] hdata, dlev, hw;
	logic [3:0] plev;
	pep_pkg::pep_pin_drive_t pdrv;
	pep_pkg::pep_data_drive_t ddrv;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;

	always #20 core_clk = ~core_clk;

	// wire levels: the block wins wherever it drives
	always_comb begin
		for (int i = 0; i < 3; i++) plev[i] = pdrv.enable[i] ? pdrv.drive[i] : hpins[i];
		plev[3] = pin3;
		dlev = ddrv.enable ? ddrv.drive : hdata;
	end

	pep_port_e dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .port_e_pin_level(plev), .port_e_pin_drive(pdrv),
		.slave_data_level(dlev), .slave_data_drive(ddrv),
		.master_clear_enable_fuse(fuse), .vpp_high_seen(vpp),
		.master_clear_request(mcr), .programming_entry(pent));

	pep_host_model host (.core_clk(core_clk), .pins(hpins), .data(hdata), .data_level(dlev));

	// ------------------------------------------------------------
	// bus and compare tasks, each entered just after a rising edge
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			$display("ERROR %0t: got %h want %h", $time, g, e);
			num_errors++;
		end
	endtask : chk

	// handshakes judged at the falling edge, where levels are settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ha, hd, hb;
		logic [1:0] r;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge core_clk);
			ha = awvalid && awready;
			hd = wvalid && wready;
			hb = bvalid;
			r = bresp;
			@(posedge core_clk);
			if (ha) awvalid <= 1'b0;
			if (hd) wvalid <= 1'b0;
		end while (hb !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, r}, {30'h0, er});
		@(posedge core_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ha, hr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge core_clk);
			ha = arvalid && arready;
			hr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge core_clk);
			if (ha) arvalid <= 1'b0;
		end while (hr !== 1'b1);
		rready <= 1'b0;
		@(posedge core_clk);
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, {24'h0, e});
		chk({30'h0, r}, {30'h0, pep_pkg::RESP_OKAY});
	endtask : rchk

	// pin outputs packed as enable, drive, master clear, programming
	task automatic ochk(input logic [7:0] e);
		@(negedge core_clk);
		chk({24'h0, pdrv.enable, pdrv.drive, mcr, pent}, {24'h0, e});
		@(posedge core_clk);
	endtask : ochk

	task automatic wrap_up;
		$display("errors %0d, checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// hang guard, far above the two hundred or so cycles the run needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h07);
		rchk(pep_pkg::OFF_ANALOG_SEL, 8'hFF);
		rchk(pep_pkg::OFF_OUTPUT_LATCH, 8'h00);
		rchk(pep_pkg::OFF_PIN_LEVELS, 8'h08);
		ochk(8'h00);
		rd(8'h14, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, pep_pkg::RESP_SLVERR});
		wr(8'h14, 8'hFF, pep_pkg::RESP_SLVERR);
		wr(pep_pkg::OFF_OUTPUT_LATCH, 8'hFF, pep_pkg::RESP_OKAY);
		rchk(pep_pkg::OFF_OUTPUT_LATCH, 8'h07);
		wr(pep_pkg::OFF_DIR_CTRL, 8'h0D, pep_pkg::RESP_OKAY);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h05);
		ochk(8'h5C);
		host.set_pins(3'h4);
		repeat (4) @(posedge core_clk);
		rchk(pep_pkg::OFF_PIN_LEVELS, 8'h08);
		wr(pep_pkg::OFF_ANALOG_SEL, 8'h9F, pep_pkg::RESP_OKAY);
		rchk(pep_pkg::OFF_PIN_LEVELS, 8'h0A);
		wr(pep_pkg::OFF_ANALOG_SEL, 8'h1F, pep_pkg::RESP_OKAY);
		rchk(pep_pkg::OFF_PIN_LEVELS, 8'h0E);
		wr(pep_pkg::OFF_PIN_LEVELS, 8'h00, pep_pkg::RESP_OKAY);
		rchk(pep_pkg::OFF_OUTPUT_LATCH, 8'h00);
		ochk(8'h40);
		rchk(pep_pkg::OFF_PIN_LEVELS, 8'h0C);
		// fuse first, pin later, so the reset request follows a real pin fall
		fuse <= 1'b1;
		vpp <= 1'b1;
		repeat (4) @(posedge core_clk);
		ochk(8'h41);
		pin3 <= 1'b0;
		repeat (4) @(posedge core_clk);
		ochk(8'h43);
		rchk(pep_pkg::OFF_PIN_LEVELS, 8'h04);
		fuse <= 1'b0;
		repeat (4) @(posedge core_clk);
		ochk(8'h41);
		pin3 <= 1'b1;
		vpp <= 1'b0;
		host.set_pins(3'h7);
		wr(pep_pkg::OFF_DIR_CTRL, 8'h17, pep_pkg::RESP_OKAY);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h17);
		host.host_write(8'hA5);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h97);
		host.host_write(8'h3C);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'hB7);
		rchk(pep_pkg::OFF_SLAVE_DATA, 8'hA5);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h37);
		wr(pep_pkg::OFF_DIR_CTRL, 8'h17, pep_pkg::RESP_OKAY);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h17);
		wr(pep_pkg::OFF_SLAVE_DATA, 8'h5A, pep_pkg::RESP_OKAY);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h57);
		host.host_read(hw);
		chk({24'h0, hw}, 32'h5A);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h17);
		wr(pep_pkg::OFF_DIR_CTRL, 8'h07, pep_pkg::RESP_OKAY);
		host.host_write(8'h11);
		rchk(pep_pkg::OFF_DIR_CTRL, 8'h07);
		wrap_up();
	end
endmodule : tb_top
